// File: common/boag_pkg.sv
// boag_pkg: constants and carrier types for the bit operand address generator
// assumes one core clock domain; encodings of modes are local to this block
package boag_pkg;
  localparam int ADDR_W     = 24;
  localparam int BITPOS_W   = 3;
  localparam int BASE11_W   = 11;
  localparam int BASE19_W   = 19;
  localparam int BASE27_W   = 27;
  localparam int FLAG_LOW_W = 8;
  localparam int SHORT_OFS  = 2;

  typedef enum logic [2:0] {
    BOAG_REG_DIRECT,
    BOAG_FLAG_DIRECT,
    BOAG_AREG_INDIRECT,
    BOAG_AREG_REL,
    BOAG_SB_REL,
    BOAG_FB_REL
  } boag_mode_type;

  typedef enum logic [1:0] {
    BOAG_BASE_11,
    BOAG_BASE_19,
    BOAG_BASE_27
  } boag_base_type;

  typedef enum logic [1:0] {
    BOAG_SIZE_BYTE,
    BOAG_SIZE_WORD,
    BOAG_SIZE_LONG
  } boag_size_type;

  typedef enum logic [1:0] {
    BOAG_JMP_SHORT,
    BOAG_JMP_BYTE,
    BOAG_JMP_WORD,
    BOAG_JMP_ABS
  } boag_jump_type;

  typedef enum logic [2:0] {
    BOAG_REGSEL_GP0_LOW,
    BOAG_REGSEL_GP0_HIGH,
    BOAG_REGSEL_GP1_LOW,
    BOAG_REGSEL_GP1_HIGH,
    BOAG_REGSEL_AP0,
    BOAG_REGSEL_AP1
  } boag_regsel_type;

  typedef enum logic [1:0] {
    BOAG_INSN_FLAG_CLEAR,
    BOAG_INSN_FLAG_SET,
    BOAG_INSN_OTHER_BIT
  } boag_insn_type;

  typedef struct packed {
    logic            valid;
    boag_mode_type   mode;
    boag_insn_type   insn;
    boag_regsel_type regsel;
    logic            pointer_sel;
    boag_base_type   base_form;
    logic [26:0]     base;
    logic [2:0]      bit_pos;
    boag_size_type   size;
  } boag_bit_req_type;

  typedef struct packed {
    logic          valid;
    boag_jump_type form;
    logic [23:0]   field;
  } boag_jump_req_type;

  typedef struct packed {
    logic [23:0] address_pointer_0;
    logic [23:0] address_pointer_1;
    logic [23:0] static_base_register;
    logic [23:0] frame_base_register;
    logic [23:0] pc;
  } boag_regs_type;
endpackage : boag_pkg

// File: hdl/boag_core.sv
// boag_core: effective bit address and branch target generation
// assumes the decoder holds request fields stable for the cycle where valid is high
`timescale 1ns/10ps
`default_nettype none
module boag_core
  import boag_pkg::*;
(
  input  wire logic                        CORE_CLK,
  input  wire logic                        RST,
  input  wire logic                        CE,
  input  wire boag_pkg::boag_bit_req_type  BIT_REQ,
  input  wire boag_pkg::boag_jump_req_type JUMP_REQ,
  input  wire boag_pkg::boag_regs_type     REGS,
  output logic                             MEM_VALID,
  output logic [boag_pkg::ADDR_W-1:0]      MEM_ADDR,
  output logic                             REG_VALID,
  output boag_pkg::boag_regsel_type        REG_SEL,
  output logic                             FLAG_VALID,
  output logic [boag_pkg::FLAG_LOW_W-1:0]  FLAG_MASK,
  output logic [7:0]                       BIT_MASK,
  output logic [2:0]                       BIT_POS,
  output logic [5:0]                       DATA_WIDTH,
  output logic                             BIT_ILLEGAL,
  output logic                             JUMP_VALID,
  output logic [boag_pkg::ADDR_W-1:0]      JUMP_TARGET
);
  import boag_pkg::*;

  // base field limited to its form width; unsigned
  function automatic logic [ADDR_W-1:0] base_unsigned(input logic [26:0] b, input boag_base_type f);
    logic [26:0] m;
    m = '0;
    unique case (f)
      BOAG_BASE_11: m = {16'h0000, b[BASE11_W-1:0]};
      BOAG_BASE_19: m = {8'h00, b[BASE19_W-1:0]};
      BOAG_BASE_27: m = b;
    endcase
    // bit field occupies the low 3 bits; byte offset above it
    return m[26:3];
  endfunction : base_unsigned

  function automatic logic [ADDR_W-1:0] base_signed(input logic [26:0] b, input boag_base_type f);
    logic [26:0] m;
    m = '0;
    unique case (f)
      BOAG_BASE_11: m = {{16{b[BASE11_W-1]}}, b[BASE11_W-1:0]};
      BOAG_BASE_19: m = {{8{b[BASE19_W-1]}}, b[BASE19_W-1:0]};
      BOAG_BASE_27: m = b;
    endcase
    return m[26:3];
  endfunction : base_signed

  logic                mem_valid, next_mem_valid;
  logic [ADDR_W-1:0]   mem_addr, next_mem_addr;
  logic                reg_valid, next_reg_valid;
  boag_regsel_type     reg_sel, next_reg_sel;
  logic                flag_valid, next_flag_valid;
  logic [7:0]          flag_mask, next_flag_mask;
  logic [7:0]          bit_mask, next_bit_mask;
  logic [2:0]          bit_pos, next_bit_pos;
  logic [5:0]          data_width, next_data_width;
  logic                bit_illegal, next_bit_illegal;
  logic                jump_valid, next_jump_valid;
  logic [ADDR_W-1:0]   jump_target, next_jump_target;
  logic [ADDR_W-1:0]   ptr;

  always_comb
  begin
    next_mem_valid   = 1'b0;
    next_mem_addr    = mem_addr;
    next_reg_valid   = 1'b0;
    next_reg_sel     = reg_sel;
    next_flag_valid  = 1'b0;
    next_flag_mask   = 8'h00;
    next_bit_mask    = bit_mask;
    next_bit_pos     = bit_pos;
    next_data_width  = data_width;
    next_bit_illegal = 1'b0;
    ptr = BIT_REQ.pointer_sel ? REGS.address_pointer_1 : REGS.address_pointer_0;
    if (BIT_REQ.valid)
    begin
      // a 3-bit field cannot leave 0..7, counted from the lsb
      next_bit_pos  = BIT_REQ.bit_pos;
      next_bit_mask = 8'h01 << BIT_REQ.bit_pos;
      unique case (BIT_REQ.size)
        BOAG_SIZE_BYTE: next_data_width = 6'h08;
        BOAG_SIZE_WORD: next_data_width = 6'h10;
        BOAG_SIZE_LONG: next_data_width = 6'h20;
        default:        next_data_width = 6'h08;
      endcase
      unique case (BIT_REQ.mode)
        BOAG_REG_DIRECT:
        begin
          // pointer targets only expose bits 7..0 through the 3-bit position
          next_reg_valid = 1'b1;
          next_reg_sel   = BIT_REQ.regsel;
        end
        BOAG_FLAG_DIRECT:
        begin
          if (BIT_REQ.insn == BOAG_INSN_OTHER_BIT)
            next_bit_illegal = 1'b1;
          else
          begin
            next_flag_valid = 1'b1;
            next_flag_mask  = 8'h01 << BIT_REQ.bit_pos;
          end
        end
        BOAG_AREG_INDIRECT:
        begin
          next_mem_valid = 1'b1;
          next_mem_addr  = ptr;
        end
        BOAG_AREG_REL:
        begin
          next_mem_valid = 1'b1;
          next_bit_pos   = BIT_REQ.base[2:0];
          next_bit_mask  = 8'h01 << BIT_REQ.base[2:0];
          // carry past bit 23 is dropped by the 24-bit sum
          next_mem_addr  = ptr + base_unsigned(BIT_REQ.base, BIT_REQ.base_form);
        end
        BOAG_SB_REL:
        begin
          if (BIT_REQ.base_form == BOAG_BASE_27)
            next_bit_illegal = 1'b1;
          else
          begin
            next_mem_valid = 1'b1;
            next_bit_pos   = BIT_REQ.base[2:0];
            next_bit_mask  = 8'h01 << BIT_REQ.base[2:0];
            next_mem_addr  = REGS.static_base_register
                             + base_unsigned(BIT_REQ.base, BIT_REQ.base_form);
          end
        end
        BOAG_FB_REL:
        begin
          if (BIT_REQ.base_form == BOAG_BASE_27)
            next_bit_illegal = 1'b1;
          else
          begin
            next_mem_valid = 1'b1;
            next_bit_pos   = BIT_REQ.base[2:0];
            next_bit_mask  = 8'h01 << BIT_REQ.base[2:0];
            next_mem_addr  = REGS.frame_base_register
                             + base_signed(BIT_REQ.base, BIT_REQ.base_form);
          end
        end
        default: next_bit_illegal = 1'b1;
      endcase
    end
  end

  always_comb
  begin
    next_jump_valid  = JUMP_REQ.valid;
    next_jump_target = jump_target;
    if (JUMP_REQ.valid)
    begin
      unique case (JUMP_REQ.form)
        BOAG_JMP_SHORT: next_jump_target = REGS.pc + ADDR_W'(SHORT_OFS) + {21'h000000, JUMP_REQ.field[2:0]};
        BOAG_JMP_BYTE:  next_jump_target = REGS.pc + {{16{JUMP_REQ.field[7]}}, JUMP_REQ.field[7:0]};
        BOAG_JMP_WORD:  next_jump_target = REGS.pc + {{8{JUMP_REQ.field[15]}}, JUMP_REQ.field[15:0]};
        BOAG_JMP_ABS:   next_jump_target = JUMP_REQ.field;
      endcase
    end
  end

  always_ff @(posedge CORE_CLK or posedge RST)
  begin
    if (RST)
    begin
      mem_valid   <= 1'b0;
      mem_addr    <= '0;
      reg_valid   <= 1'b0;
      reg_sel     <= BOAG_REGSEL_GP0_LOW;
      flag_valid  <= 1'b0;
      flag_mask   <= 8'h00;
      bit_mask    <= 8'h01;
      bit_pos     <= 3'h0;
      data_width  <= 6'h08;
      bit_illegal <= 1'b0;
      jump_valid  <= 1'b0;
      jump_target <= '0;
    end
    else if (CE)
    begin
      mem_valid   <= next_mem_valid;
      mem_addr    <= next_mem_addr;
      reg_valid   <= next_reg_valid;
      reg_sel     <= next_reg_sel;
      flag_valid  <= next_flag_valid;
      flag_mask   <= next_flag_mask;
      bit_mask    <= next_bit_mask;
      bit_pos     <= next_bit_pos;
      data_width  <= next_data_width;
      bit_illegal <= next_bit_illegal;
      jump_valid  <= next_jump_valid;
      jump_target <= next_jump_target;
    end
  end

  assign MEM_VALID   = mem_valid;
  assign MEM_ADDR    = mem_addr;
  assign REG_VALID   = reg_valid;
  assign REG_SEL     = reg_sel;
  assign FLAG_VALID  = flag_valid;
  assign FLAG_MASK   = flag_mask;
  assign BIT_MASK    = bit_mask;
  assign BIT_POS     = bit_pos;
  assign DATA_WIDTH  = data_width;
  assign BIT_ILLEGAL = bit_illegal;
  assign JUMP_VALID  = jump_valid;
  assign JUMP_TARGET = jump_target;

  property p_flag_only_flag_clear_instruction_flag_set_instruction;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && BIT_REQ.valid && BIT_REQ.mode == BOAG_FLAG_DIRECT && BIT_REQ.insn == BOAG_INSN_OTHER_BIT)
      |=> BIT_ILLEGAL && !FLAG_VALID;
  endproperty
  a_flag_only_flag_clear_instruction_flag_set_instruction: assert property (p_flag_only_flag_clear_instruction_flag_set_instruction) else $error("flag direct accepted for other bit insn");

  property p_flag_onehot;
    @(posedge CORE_CLK) disable iff (RST)
    FLAG_VALID |-> $onehot(FLAG_MASK) && FLAG_MASK == BIT_MASK;
  endproperty
  a_flag_onehot: assert property (p_flag_onehot) else $error("flag mask not a single low bit");

  property p_areg_indirect;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && BIT_REQ.valid && BIT_REQ.mode == BOAG_AREG_INDIRECT && !BIT_REQ.pointer_sel)
      |=> MEM_VALID && MEM_ADDR == $past(REGS.address_pointer_0);
  endproperty
  a_areg_indirect: assert property (p_areg_indirect) else $error("indirect address wrong");

  property p_sb_rel;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && BIT_REQ.valid && BIT_REQ.mode == BOAG_SB_REL && BIT_REQ.base_form == BOAG_BASE_11)
      |=> MEM_ADDR == ADDR_W'($past(REGS.static_base_register) + $past(BIT_REQ.base[10:3]));
  endproperty
  a_sb_rel: assert property (p_sb_rel) else $error("static base address wrong");

  property p_sb_no27;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && BIT_REQ.valid && BIT_REQ.mode == BOAG_SB_REL && BIT_REQ.base_form == BOAG_BASE_27)
      |=> BIT_ILLEGAL && !MEM_VALID;
  endproperty
  a_sb_no27: assert property (p_sb_no27) else $error("static base accepted 27-bit form");

  property p_fb_rel;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && BIT_REQ.valid && BIT_REQ.mode == BOAG_FB_REL && BIT_REQ.base_form == BOAG_BASE_11)
      |=> MEM_ADDR == ADDR_W'($past(REGS.frame_base_register)
                     + {{16{$past(BIT_REQ.base[10])}}, $past(BIT_REQ.base[10:3])});
  endproperty
  a_fb_rel: assert property (p_fb_rel) else $error("frame base address wrong");

  property p_short_range;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && JUMP_REQ.valid && JUMP_REQ.form == BOAG_JMP_SHORT)
      |=> (ADDR_W'(JUMP_TARGET - $past(REGS.pc)) >= 24'h000002) && (ADDR_W'(JUMP_TARGET - $past(REGS.pc)) <= 24'h000009);
  endproperty
  a_short_range: assert property (p_short_range) else $error("short branch out of range");

  property p_abs_jump;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && JUMP_REQ.valid && JUMP_REQ.form == BOAG_JMP_ABS) |=> JUMP_VALID && JUMP_TARGET == $past(JUMP_REQ.field);
  endproperty
  a_abs_jump: assert property (p_abs_jump) else $error("absolute target wrong");

  property p_width;
    @(posedge CORE_CLK) disable iff (RST)
    (CE && BIT_REQ.valid && BIT_REQ.size == BOAG_SIZE_WORD) |=> DATA_WIDTH == 6'h10;
  endproperty
  a_width: assert property (p_width) else $error("word width wrong");
endmodule : boag_core
`default_nettype wire

// File: tb/boag_core_test.sv
// boag_core_test: self-checking bench for the bit operand address generator
// assumes boag_pkg and boag_core are compiled first; one 100 MHz clock, no partner
`timescale 1ns/10ps
`default_nettype none
module boag_core_test;
  import boag_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst      = 1'b1;
  logic              ce       = 1'b1;
  boag_bit_req_type  breq     = '0;
  boag_jump_req_type jreq     = '0;
  boag_regs_type     regs     = '0;
  logic              mem_valid, reg_valid, flag_valid, bit_illegal, jump_valid;
  logic [23:0]       mem_addr, jump_target;
  boag_regsel_type   reg_sel;
  logic [7:0]        flag_mask, bit_mask;
  logic [2:0]        bit_pos;
  logic [5:0]        data_width;
  int                error_cnt   = 0;
  int                checks_done = 0;

  boag_core dut (
    .CORE_CLK    (core_clk),
    .RST         (rst),
    .CE          (ce),
    .BIT_REQ     (breq),
    .JUMP_REQ    (jreq),
    .REGS        (regs),
    .MEM_VALID   (mem_valid),
    .MEM_ADDR    (mem_addr),
    .REG_VALID   (reg_valid),
    .REG_SEL     (reg_sel),
    .FLAG_VALID  (flag_valid),
    .FLAG_MASK   (flag_mask),
    .BIT_MASK    (bit_mask),
    .BIT_POS     (bit_pos),
    .DATA_WIDTH  (data_width),
    .BIT_ILLEGAL (bit_illegal),
    .JUMP_VALID  (jump_valid),
    .JUMP_TARGET (jump_target)
  );

  always #5 core_clk = ~core_clk;

  task automatic stop_test;
    if (error_cnt == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp)
    begin
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
      error_cnt++;
    end
  endtask : chk

  // one request cycle; outputs are looked at one edge later, after they settle
  task automatic fire(input logic bv, input logic jv);
    @(posedge core_clk);
    #1;
    breq.valid = bv;
    jreq.valid = jv;
    @(posedge core_clk);
    #1;
    breq.valid = 1'b0;
    jreq.valid = 1'b0;
  endtask : fire

  task automatic mem(input boag_mode_type m, input boag_base_type f, input logic [26:0] b,
                     input logic [23:0] exp, input logic [2:0] bp);
    breq.mode      = m;
    breq.base_form = f;
    breq.base      = b;
    fire(1'b1, 1'b0);
    chk("mem_valid", 1, mem_valid);
    chk("mem_addr", exp, mem_addr);
    chk("bit_mask", 8'h01 << bp, bit_mask);
    chk("bit_pos", bp, bit_pos);
  endtask : mem

  // refused requests must give no memory, flag or register valid pulse
  task automatic bad(input boag_mode_type m, input boag_insn_type i, input boag_base_type f);
    breq.mode      = m;
    breq.insn      = i;
    breq.base_form = f;
    fire(1'b1, 1'b0);
    chk("bit_illegal", 1, bit_illegal);
    chk("no_valid", 0, {mem_valid, flag_valid, reg_valid});
  endtask : bad

  task automatic t_reg_direct;
    breq.mode = BOAG_REG_DIRECT;
    for (int r = 0; r < 6; r++)
      for (int p = 0; p < 8; p += 7)
      begin
        breq.regsel  = boag_regsel_type'(r);
        breq.bit_pos = p[2:0];
        fire(1'b1, 1'b0);
        chk("reg_valid", 1, {mem_valid, reg_valid});
        chk("reg_sel", r, reg_sel);
        chk("bit_mask", 8'h01 << p, bit_mask);
      end
  endtask : t_reg_direct

  task automatic t_flag;
    breq.mode = BOAG_FLAG_DIRECT;
    for (int i = 0; i < 2; i++)
      for (int p = 0; p < 8; p += 7)
      begin
        breq.insn    = boag_insn_type'(i);
        breq.bit_pos = p[2:0];
        fire(1'b1, 1'b0);
        chk("flag_valid", 1, {bit_illegal, flag_valid});
        chk("flag_mask", 8'h01 << p, flag_mask);
      end
    bad(BOAG_FLAG_DIRECT, BOAG_INSN_OTHER_BIT, BOAG_BASE_11);
  endtask : t_flag

  task automatic t_indirect;
    regs.address_pointer_0 = 24'hffffff;
    regs.address_pointer_1 = 24'h123456;
    breq.bit_pos           = 3'd5;
    breq.pointer_sel       = 1'b0;
    mem(BOAG_AREG_INDIRECT, BOAG_BASE_11, '0, 24'hffffff, 3'd5);
    breq.pointer_sel = 1'b1;
    mem(BOAG_AREG_INDIRECT, BOAG_BASE_11, '0, 24'h123456, 3'd5);
    fire(1'b0, 1'b0);
    chk("pulse_end", 0, mem_valid);
    chk("addr_hold", 24'h123456, mem_addr);
  endtask : t_indirect

  // pointer 1 sits near the top so every form runs past it and wraps
  task automatic t_areg_rel;
    regs.address_pointer_0 = 24'h000000;
    regs.address_pointer_1 = 24'hfffff0;
    breq.pointer_sel       = 1'b1;
    mem(BOAG_AREG_REL, BOAG_BASE_11, {16'h0, 8'hff, 3'd3}, 24'h0000ef, 3'd3);
    mem(BOAG_AREG_REL, BOAG_BASE_19, {8'h0, 16'hffff, 3'd6}, 24'h00ffef, 3'd6);
    mem(BOAG_AREG_REL, BOAG_BASE_27, {24'hffffff, 3'd0}, 24'hffffef, 3'd0);
    mem(BOAG_AREG_REL, BOAG_BASE_27, {24'h000010, 3'd1}, 24'h000000, 3'd1);
  endtask : t_areg_rel

  task automatic t_sb_rel;
    regs.static_base_register = 24'hffff00;
    mem(BOAG_SB_REL, BOAG_BASE_11, {16'h0, 8'h80, 3'd2}, 24'hffff80, 3'd2);
    mem(BOAG_SB_REL, BOAG_BASE_19, {8'h0, 16'h0100, 3'd7}, 24'h000000, 3'd7);
    bad(BOAG_SB_REL, BOAG_INSN_OTHER_BIT, BOAG_BASE_27);
  endtask : t_sb_rel

  task automatic t_fb_rel;
    regs.frame_base_register = 24'h000004;
    mem(BOAG_FB_REL, BOAG_BASE_11, {16'h0, 8'hf8, 3'd5}, 24'hfffffc, 3'd5);
    mem(BOAG_FB_REL, BOAG_BASE_11, {16'h0, 8'h7f, 3'd1}, 24'h000083, 3'd1);
    mem(BOAG_FB_REL, BOAG_BASE_19, {8'h0, 16'h7fff, 3'd0}, 24'h008003, 3'd0);
    bad(BOAG_FB_REL, BOAG_INSN_OTHER_BIT, BOAG_BASE_27);
    bad(boag_mode_type'(3'h7), BOAG_INSN_OTHER_BIT, BOAG_BASE_11);
  endtask : t_fb_rel

  task automatic t_size;
    breq.mode = BOAG_REG_DIRECT;
    for (int s = 0; s < 3; s++)
    begin
      breq.size = boag_size_type'(s);
      fire(1'b1, 1'b0);
      chk("data_width", 8 << s, data_width);
    end
  endtask : t_size

  // jumps run in the same cycle as a bit request to show the paths are apart
  task automatic t_jump;
    boag_jump_type fm [8] = '{BOAG_JMP_SHORT, BOAG_JMP_SHORT, BOAG_JMP_BYTE, BOAG_JMP_BYTE,
                              BOAG_JMP_WORD, BOAG_JMP_WORD, BOAG_JMP_ABS, BOAG_JMP_ABS};
    logic [23:0]   fd [8] = '{24'h000000, 24'hfffff7, 24'h000080, 24'h00007f,
                              24'h008000, 24'h007fff, 24'hffffff, 24'h000000};
    logic [23:0]   ex [8] = '{24'h000000, 24'h000007, 24'hffff7e, 24'h00007d,
                              24'hff7ffe, 24'h007ffd, 24'hffffff, 24'h000000};
    regs.pc   = 24'hfffffe;
    breq.mode = BOAG_REG_DIRECT;
    for (int k = 0; k < 8; k++)
    begin
      jreq.form  = fm[k];
      jreq.field = fd[k];
      fire(1'b1, 1'b1);
      chk("jump_valid", 2'b11, {jump_valid, reg_valid});
      chk("jump_target", ex[k], jump_target);
    end
  endtask : t_jump

  // with the enable low a request is not taken and the address holds
  task automatic t_hold;
    fire(1'b0, 1'b0);
    ce = 1'b0;
    regs.address_pointer_0 = 24'h0a0a0a;
    breq.pointer_sel       = 1'b0;
    breq.mode              = BOAG_AREG_INDIRECT;
    fire(1'b1, 1'b0);
    chk("ce_no_pulse", 0, mem_valid);
    chk("ce_addr", 24'h008003, mem_addr);
    ce = 1'b1;
  endtask : t_hold

  initial
  begin
    repeat (5) @(posedge core_clk);
    chk("rst_pulses", 0, {mem_valid, reg_valid, flag_valid, bit_illegal, jump_valid});
    chk("rst_width", 8, data_width);
    chk("rst_mask", 8'h01, bit_mask);
    #1;
    rst = 1'b0;
    t_reg_direct();
    t_flag();
    t_indirect();
    t_areg_rel();
    t_sb_rel();
    t_fb_rel();
    t_size();
    t_jump();
    t_hold();
    stop_test();
  end

  // about 95 cycles of work; a twentyfold margin before calling it a hang
  initial
  begin
    repeat (2000) @(posedge core_clk);
    error_cnt++;
    stop_test();
  end
endmodule : boag_core_test
`default_nettype wire
